/* File: hw/fpu_status_word.sv */
// status word register bank of the stack floating-point unit
//
// Behaviour
// [R1] a 16-bit status word holds top, condition codes, summary, fault, flags
// [R2] top-of-stack pointer sits in bits 11 to 13, unsigned 0 to 7
// [R3] store-status copies the whole word to memory or the accumulator
// [R4] with invalid and stack fault set, code one is 1 overflow, 0 underflow
// [R5] with inexact set, code one is 1 when last rounding went up
// [R6] examine loads code one with sign, other codes with operand class
// [R7] remainder sets code two if incomplete, else quotient bits into 0,3,1
// [R8] trigonometric ops set code two when source is out of range
// [R9] bits 0 to 5 hold six exception flags set on detection
// [R10] error summary bit 7 is set when any unmasked flag is set
// [R11] masked exceptions still set their flag but not the summary
// [R12] summary becoming set raises the exception handler request
// [R13] exception flags stick until clear, init, save or restore; there is no save class, so only clear, init and restore drop them
// [R14] bit 15 busy always mirrors the error summary
// [R15] compare and test write result into codes 0, 2, 3; one cleared; the code sets one to 1 on a stack overflow fault
// [R16] flag-setting compares leave codes 0,2,3; code one shows fault only
// [R17] arithmetic class leaves 0,2,3; code one is round-up or fault
// [R18] trig code one is round-up or fault, undefined when out of range
// [R19] load, abs, negate and similar clear code one unless stack fault
// [R20] load-environment and restore load all codes from the image
// [R21] control, no-op and store instructions leave codes undefined
// [R22] consumers must not rely on undefined condition codes
// [R23] initialize and save-state clear all four condition codes; there is no save-state class, so only init clears them
// [R24] compare codes 3,2,0: greater 000, less 001, equal 100, unordered 111
// [R25] push decrements top, pop increments, 0 minus one wraps to 7
// [R26] bit 6 is a sticky stack fault flag set on stack over/underflow
// [R27] control word bits 0 to 5 mask the matching exceptions
`timescale 1ns/1ns
`include "fpu_status_params.svh"

module fpu_status_word
  import fpu_status_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  complete,
  input  wire instr_class_t          instrClass,
  input  wire stack_adjust_t         stackAdjust,
  input  wire logic [`EXC_COUNT-1:0] excDetect,
  input  wire logic                  stackFault,
  input  wire logic                  stackOverflow,
  input  wire logic                  roundedUp,
  input  wire cmp_result_t           compareResult,
  input  wire logic                  operandSign,
  input  wire logic [2:0]            operandClass,
  input  wire logic                  remIncomplete,
  input  wire logic [2:0]            quotientLow,
  input  wire logic                  trigOutOfRange,
  input  wire logic                  storeToAccumulator,
  input  wire logic [`FSW_WIDTH-1:0] restoreWord,
  input  wire logic [`EXC_COUNT-1:0] controlMask,
  output logic      [`FSW_WIDTH-1:0] float_unit_status_word,
  output logic                       handlerReq,
  output logic      [`FSW_WIDTH-1:0] storeData,
  output logic                       storeToAcc,
  output logic                       storeToMem
);

  // ==========================================================
  // state
  fsw_state_t state_r;
  fsw_state_t state_nxt;

  logic [3:0]            ccOld;
  logic [3:0]            ccNew;
  logic [3:0]            restoreCc;
  logic [`EXC_COUNT-1:0] flagsNow;

  assign ccOld     = {state_r.statusWord[`BIT_CC3], state_r.statusWord[`BIT_CC2],
                      state_r.statusWord[`BIT_CC1], state_r.statusWord[`BIT_CC0]};
  assign restoreCc = {restoreWord[`BIT_CC3], restoreWord[`BIT_CC2],
                      restoreWord[`BIT_CC1], restoreWord[`BIT_CC0]};
  assign flagsNow  = state_r.statusWord[`EXC_COUNT-1:0];

  // ==========================================================
  // condition codes
  fpu_cond_code_unit ccUnit (
    .instrClass     (instrClass),
    .stackFault     (stackFault),
    .stackOverflow  (stackOverflow),
    .inexactDetect  (excDetect[`BIT_INEXACT]),
    .roundedUp      (roundedUp),
    .compareResult  (compareResult),
    .operandSign    (operandSign),
    .operandClass   (operandClass),
    .remIncomplete  (remIncomplete),
    .quotientLow    (quotientLow),
    .trigOutOfRange (trigOutOfRange),
    .restoreCc      (restoreCc),
    .ccOld          (ccOld),
    .ccNew          (ccNew)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic [`FSW_WIDTH-1:0] w;
    logic                  sumNew;
    w      = state_r.statusWord;
    sumNew = 1'b0;
    state_nxt            = state_r;
    state_nxt.storeToAcc = 1'b0;
    state_nxt.storeToMem = 1'b0;
    if (complete) begin
      // [R3] copy word out
      if (instrClass == CLS_STORE_STATUS) begin
        state_nxt.storeData  = state_r.statusWord;
        state_nxt.storeToAcc = storeToAccumulator;
        state_nxt.storeToMem = !storeToAccumulator;
      end
      // [R13] [R23] clearing instructions
      case (instrClass)
        CLS_CLEAR_EXC: w[`BIT_STACKFAULT:0] = 7'h00;
        CLS_INIT:      w = `FSW_RESET;
        CLS_RESTORE:   w = restoreWord;
        default:       w = state_r.statusWord;
      endcase
      // [R2] [R25] stack pointer wraps
      case (stackAdjust)
        STK_PUSH: w[`TOP_MSB:`TOP_LSB] = w[`TOP_MSB:`TOP_LSB] - 3'h1;
        STK_POP:  w[`TOP_MSB:`TOP_LSB] = w[`TOP_MSB:`TOP_LSB] + 3'h1;
        default:  w[`TOP_MSB:`TOP_LSB] = w[`TOP_MSB:`TOP_LSB];
      endcase
      // [R9] [R11] detection sets flags after any clear
      w[`EXC_COUNT-1:0] = w[`EXC_COUNT-1:0] | excDetect;
      // [R26] [R4] stack fault also flags invalid
      if (stackFault) begin
        w[`BIT_STACKFAULT] = 1'b1;
        w[`BIT_INVALID]    = 1'b1;
      end
      {w[`BIT_CC3], w[`BIT_CC2], w[`BIT_CC1], w[`BIT_CC0]} = ccNew;
    end
    // [R10] [R27] summary of unmasked flags
    sumNew          = |(w[`EXC_COUNT-1:0] & ~controlMask);
    w[`BIT_ERRSUM]  = sumNew;
    // [R14] busy mirrors summary
    w[`BIT_BUSY]    = sumNew;
    state_nxt.statusWord = w;
    // [R12] handler request on rising summary
    state_nxt.handlerReq = sumNew & ~state_r.statusWord[`BIT_ERRSUM];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r.statusWord <= `FSW_RESET;
      state_r.handlerReq <= 1'b0;
      state_r.storeData  <= `FSW_RESET;
      state_r.storeToAcc <= 1'b0;
      state_r.storeToMem <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // [R1] word straight from the register
  assign float_unit_status_word = state_r.statusWord;
  assign handlerReq             = state_r.handlerReq;
  assign storeData              = state_r.storeData;
  assign storeToAcc             = state_r.storeToAcc;
  assign storeToMem             = state_r.storeToMem;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [2:0] topNow;
  logic       doneCls;
  logic       storeReq;
  assign topNow   = state_r.statusWord[`TOP_MSB:`TOP_LSB];
  assign doneCls  = complete && !stackFault;
  assign storeReq = complete && instrClass == CLS_STORE_STATUS;

  sequence s_init;
    complete && instrClass == CLS_INIT;
  endsequence

  sequence s_push;
    complete && stackAdjust == STK_PUSH && instrClass != CLS_INIT
      && instrClass != CLS_RESTORE;
  endsequence

  sequence s_pop;
    complete && stackAdjust == STK_POP && instrClass != CLS_INIT
      && instrClass != CLS_RESTORE;
  endsequence

  sequence s_cmp_equal;
    doneCls && instrClass == CLS_COMPARE && compareResult == CMP_EQUAL;
  endsequence

  property p_busy_mirror;
    state_r.statusWord[`BIT_BUSY] == state_r.statusWord[`BIT_ERRSUM];
  endproperty
  a_busy_mirror: assert property (p_busy_mirror) else $error("busy differs from summary"); // [R14]

  property p_top_push;
    s_push |=> topNow == $past(topNow) - 3'h1;
  endproperty
  a_top_push: assert property (p_top_push) else $error("push did not lower top"); // [R25]

  property p_sticky;
    !(complete && (instrClass == CLS_CLEAR_EXC || instrClass == CLS_INIT
      || instrClass == CLS_RESTORE))
      |=> (flagsNow & $past(flagsNow)) == $past(flagsNow);
  endproperty
  a_sticky: assert property (p_sticky) else $error("exception flag lost"); // [R13]

  property p_flag_set;
    complete && instrClass != CLS_RESTORE |=> (flagsNow & $past(excDetect)) == $past(excDetect);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("detected exception not flagged"); // [R9]

  property p_summary;
    ##1 state_r.statusWord[`BIT_ERRSUM] == |(flagsNow & ~$past(controlMask));
  endproperty
  a_summary: assert property (p_summary) else $error("summary wrong"); // [R10]

  property p_masked;
    complete && (excDetect & ~controlMask) == 6'h00 && (flagsNow & ~controlMask) == 6'h00
      && !stackFault && instrClass != CLS_RESTORE
      |=> !state_r.statusWord[`BIT_ERRSUM];
  endproperty
  a_masked: assert property (p_masked) else $error("masked exception set summary"); // [R11]

  property p_handler;
    $rose(state_r.statusWord[`BIT_ERRSUM]) |-> handlerReq ##1 !handlerReq;
  endproperty
  a_handler: assert property (p_handler) else $error("handler request missing"); // [R12]

  property p_init;
    s_init |=> ccOld == 4'h0 && flagsNow == 6'h00 && topNow == 3'h0;
  endproperty
  a_init: assert property (p_init) else $error("init did not clear"); // [R23]

  property p_cmp_equal;
    s_cmp_equal |=> ccOld == 4'b1000;
  endproperty
  a_cmp_equal: assert property (p_cmp_equal) else $error("equal compare wrong"); // [R24]

  property p_fault_dir;
    complete && stackFault && instrClass == CLS_ARITH
      |=> state_r.statusWord[`BIT_CC1] == $past(stackOverflow)
          && state_r.statusWord[`BIT_STACKFAULT] && flagsNow[`BIT_INVALID];
  endproperty
  a_fault_dir: assert property (p_fault_dir) else $error("fault direction wrong"); // [R4]

  property p_roundup;
    doneCls && instrClass == CLS_ARITH && excDetect[`BIT_INEXACT]
      |=> state_r.statusWord[`BIT_CC1] == $past(roundedUp);
  endproperty
  a_roundup: assert property (p_roundup) else $error("round-up code wrong"); // [R5]

  property p_examine;
    complete && instrClass == CLS_EXAMINE
      |=> ccOld == {$past(operandClass[2:1]), $past(operandSign), $past(operandClass[0])};
  endproperty
  a_examine: assert property (p_examine) else $error("examine codes wrong"); // [R6]

  property p_remainder;
    doneCls && instrClass == CLS_REMAINDER && !remIncomplete
      |=> ccOld == {$past(quotientLow[1]), 1'b0, $past(quotientLow[0]), $past(quotientLow[2])};
  endproperty
  a_remainder: assert property (p_remainder) else $error("remainder codes wrong"); // [R7]

  property p_trig;
    complete && instrClass == CLS_TRIG |=> state_r.statusWord[`BIT_CC2] == $past(trigOutOfRange);
  endproperty
  a_trig: assert property (p_trig) else $error("range code wrong"); // [R8]

  property p_store;
    storeReq
      |=> (storeToAcc ^ storeToMem) && storeData == $past(state_r.statusWord)
          ##1 (!storeToAcc || $past(storeReq));
  endproperty
  a_store: assert property (p_store) else $error("store copy wrong"); // [R3]

  property p_restore;
    complete && instrClass == CLS_RESTORE && stackAdjust == STK_NONE && excDetect == 6'h00
      && !stackFault |=> ccOld == $past(restoreCc) && topNow == $past(restoreWord[13:11]);
  endproperty
  a_restore: assert property (p_restore) else $error("restore codes wrong"); // [R20]

  property p_top_pop;
    s_pop |=> topNow == $past(topNow) + 3'h1;
  endproperty
  a_top_pop: assert property (p_top_pop) else $error("pop did not raise top"); // [R25] [R2]

  property p_clear_exc;
    complete && instrClass == CLS_CLEAR_EXC && excDetect == 6'h00 && !stackFault
      |=> state_r.statusWord[`BIT_STACKFAULT:0] == 7'h00;
  endproperty
  a_clear_exc: assert property (p_clear_exc) else $error("flags not cleared"); // [R13]

  property p_fault_sticky;
    complete && stackFault |=> state_r.statusWord[`BIT_STACKFAULT];
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault not sticky"); // [R26]

  property p_load_one;
    complete && instrClass == CLS_LOAD_MISC
      |=> state_r.statusWord[`BIT_CC1] == ($past(stackFault) && $past(stackOverflow));
  endproperty
  a_load_one: assert property (p_load_one) else $error("load code one wrong"); // [R19]

  property p_cmp_one;
    complete && (instrClass == CLS_COMPARE || instrClass == CLS_COMPARE_FLAGS)
      |=> state_r.statusWord[`BIT_CC1] == ($past(stackFault) && $past(stackOverflow));
  endproperty
  a_cmp_one: assert property (p_cmp_one) else $error("compare code one"); // [R15] [R16]

endmodule

/* File: hw/fpu_status_params.svh */
// bit positions, reset value and field widths of the status word
`ifndef FPU_STATUS_PARAMS_SVH
`define FPU_STATUS_PARAMS_SVH

`define FSW_WIDTH       16
`define FSW_RESET       16'h0000
`define EXC_COUNT       6
`define TOP_WIDTH       3

`define BIT_INVALID     0
`define BIT_DENORMAL    1
`define BIT_DIVZERO     2
`define BIT_OVERFLOW    3
`define BIT_UNDERFLOW   4
`define BIT_INEXACT     5
`define BIT_STACKFAULT  6
`define BIT_ERRSUM      7
`define BIT_CC0         8
`define BIT_CC1         9
`define BIT_CC2         10
`define TOP_LSB         11
`define TOP_MSB         13
`define BIT_CC3         14
`define BIT_BUSY        15

`endif

/* File: hw/fpu_status_pkg.sv */
// types shared by the status word logic
`include "fpu_status_params.svh"

package fpu_status_pkg;

  // class of the instruction that completes
  typedef enum logic [3:0] {
    CLS_COMPARE,
    CLS_COMPARE_FLAGS,
    CLS_ARITH,
    CLS_TRIG,
    CLS_LOAD_MISC,
    CLS_EXAMINE,
    CLS_REMAINDER,
    CLS_CLEAR_EXC,
    CLS_INIT,
    CLS_RESTORE,
    CLS_STORE_STATUS,
    CLS_NO_CC
  } instr_class_t;

  typedef enum logic [1:0] {
    CMP_GREATER,
    CMP_LESS,
    CMP_EQUAL,
    CMP_UNORDERED
  } cmp_result_t;

  typedef enum logic [1:0] {
    STK_NONE,
    STK_PUSH,
    STK_POP
  } stack_adjust_t;

  typedef struct packed {
    logic [`FSW_WIDTH-1:0] statusWord;
    logic                  handlerReq;
    logic [`FSW_WIDTH-1:0] storeData;
    logic                  storeToAcc;
    logic                  storeToMem;
  } fsw_state_t;

endpackage

/* File: hw/fpu_cond_code_unit.sv */
// next value of the four condition codes for a completing instruction
`timescale 1ns/1ns

module fpu_cond_code_unit
  import fpu_status_pkg::*;
(
  input  wire instr_class_t instrClass,
  input  wire logic         stackFault,
  input  wire logic         stackOverflow,
  input  wire logic         inexactDetect,
  input  wire logic         roundedUp,
  input  wire cmp_result_t  compareResult,
  input  wire logic         operandSign,
  input  wire logic [2:0]   operandClass,
  input  wire logic         remIncomplete,
  input  wire logic [2:0]   quotientLow,
  input  wire logic         trigOutOfRange,
  input  wire logic [3:0]   restoreCc,
  input  wire logic [3:0]   ccOld,
  output logic      [3:0]   ccNew
);

  // cond code one: fault direction, else round-up, else zero
  function automatic logic codeOneStatus(input logic fault, input logic ovf,
                                         input logic inexact, input logic up);
    codeOneStatus = fault ? ovf : (inexact & up);
  endfunction

  // ccNew order is {three, two, one, zero}
  always_comb begin
    ccNew = ccOld;
    case (instrClass)
      // [R15] [R24] compare encoding
      CLS_COMPARE: begin
        case (compareResult)
          CMP_GREATER: {ccNew[3], ccNew[2], ccNew[0]} = 3'b000;
          CMP_LESS:    {ccNew[3], ccNew[2], ccNew[0]} = 3'b001;
          CMP_EQUAL:   {ccNew[3], ccNew[2], ccNew[0]} = 3'b100;
          default:     {ccNew[3], ccNew[2], ccNew[0]} = 3'b111;
        endcase
        ccNew[1] = codeOneStatus(stackFault, stackOverflow, 1'b0, 1'b0);
      end
      // [R16] only fault status
      CLS_COMPARE_FLAGS: ccNew[1] = codeOneStatus(stackFault, stackOverflow, 1'b0, 1'b0);
      // [R4] [R5] [R17] round-up or fault
      CLS_ARITH: ccNew[1] = codeOneStatus(stackFault, stackOverflow, inexactDetect, roundedUp);
      // [R8] [R18] range flag
      CLS_TRIG: begin
        ccNew[2] = trigOutOfRange;
        if (!trigOutOfRange) begin
          ccNew[1] = codeOneStatus(stackFault, stackOverflow, inexactDetect, roundedUp);
        end
      end
      // [R19] clear unless fault
      CLS_LOAD_MISC: ccNew[1] = codeOneStatus(stackFault, stackOverflow, 1'b0, 1'b0);
      // [R6] sign and class
      CLS_EXAMINE: begin
        ccNew[1] = operandSign;
        {ccNew[3], ccNew[2], ccNew[0]} = operandClass;
      end
      // [R7] quotient bits
      CLS_REMAINDER: begin
        ccNew[2] = remIncomplete;
        if (!remIncomplete) begin
          ccNew[0] = quotientLow[2];
          ccNew[3] = quotientLow[1];
          ccNew[1] = stackFault ? stackOverflow : quotientLow[0];
        end
      end
      // [R23] init clears codes
      CLS_INIT: ccNew = 4'h0;
      // [R20] codes from image
      CLS_RESTORE: ccNew = restoreCc;
      // [R21] codes left as they were
      default: ccNew = ccOld;
    endcase
  end

endmodule

/* File: bench/fpu_datapath_model.sv */
// datapath and sequencer model that hands completions to the status word
`timescale 1ns/1ns

module fpu_datapath_model
  import fpu_status_pkg::*;
(
  input  wire logic     clk,
  output instr_class_t  instrClass,
  output stack_adjust_t stackAdjust,
  output cmp_result_t   compareResult,
  output logic          complete,
  output logic [5:0]    excDetect,
  output logic          stackFault,
  output logic          stackOverflow,
  output logic          roundedUp,
  output logic          operandSign,
  output logic [2:0]    operandClass,
  output logic          remIncomplete,
  output logic [2:0]    quotientLow,
  output logic          trigOutOfRange,
  output logic          storeToAccumulator,
  output logic [15:0]   restoreWord
);
  // ==========================================
  // result fields
  task zero();
    instrClass = CLS_NO_CC;
    stackAdjust = STK_NONE;
    compareResult = CMP_GREATER;
    {excDetect, stackFault, stackOverflow, roundedUp, operandSign, operandClass,
     remIncomplete, quotientLow, trigOutOfRange, storeToAccumulator, restoreWord} = '0;
  endtask

  initial begin
    complete = 1'b0;
    zero();
  end

  // next free cycle, fields cleared for the caller to fill
  task prep();
    @(posedge clk);
    #1;
    zero();
  endtask

  // ==========================================
  // one completion, then fields scrambled
  task issue(input instr_class_t c);
    complete = 1'b1;
    instrClass = c;
    @(posedge clk);
    #1;
    complete = 1'b0;
    {excDetect, stackFault, stackOverflow, roundedUp, operandSign, operandClass,
     remIncomplete, quotientLow, trigOutOfRange, storeToAccumulator, restoreWord} =
    ~{excDetect, stackFault, stackOverflow, roundedUp, operandSign, operandClass,
     remIncomplete, quotientLow, trigOutOfRange, storeToAccumulator, restoreWord};
  endtask
endmodule

/* File: bench/fpu_status_word_logic_test.sv */
// self-checking bench of the status word logic
`timescale 1ns/1ns

module fpu_status_word_logic_test;
  import fpu_status_pkg::*;

  logic          clk = 1'b0;
  logic          reset = 1'b1;
  logic [5:0]    controlMask = 6'h00;
  instr_class_t  instrClass;
  stack_adjust_t stackAdjust;
  cmp_result_t   compareResult;
  logic          complete, stackFault, stackOverflow, roundedUp, operandSign;
  logic          remIncomplete, trigOutOfRange, storeToAccumulator;
  logic [5:0]    excDetect;
  logic [2:0]    operandClass, quotientLow;
  logic [15:0]   restoreWord, w, storeData;
  logic          handlerReq, storeToAcc, storeToMem;
  int            checks = 0;
  int            n_fail = 0;

  always #25 clk = ~clk;

  fpu_datapath_model mdl (.clk, .instrClass, .stackAdjust, .compareResult, .complete,
    .excDetect, .stackFault, .stackOverflow, .roundedUp, .operandSign, .operandClass,
    .remIncomplete, .quotientLow, .trigOutOfRange, .storeToAccumulator, .restoreWord);

  fpu_status_word dut_u (.clk, .reset, .complete, .instrClass, .stackAdjust, .excDetect,
    .stackFault, .stackOverflow, .roundedUp, .compareResult, .operandSign, .operandClass,
    .remIncomplete, .quotientLow, .trigOutOfRange, .storeToAccumulator, .restoreWord,
    .controlMask, .float_unit_status_word(w), .handlerReq, .storeData, .storeToAcc,
    .storeToMem);

  // ==========================================
  // compare and verdict
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task results();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  task t_cmp();
    logic [2:0] e [4];
    e = '{3'b000, 3'b001, 3'b100, 3'b111};
    for (int i = 0; i < 4; i++) begin
      mdl.prep();
      mdl.compareResult = cmp_result_t'(i);
      mdl.roundedUp = 1'b1;
      mdl.issue(CLS_COMPARE);
      chk("cmp", 16'(e[i]), 16'({w[14], w[10], w[8]}));
      chk("cmp code one", 16'h0, 16'(w[9]));
    end
    $display("test compare done");
  endtask

  task t_stack();
    mdl.prep();
    mdl.stackAdjust = STK_PUSH;
    mdl.issue(CLS_LOAD_MISC);
    chk("top", 16'h7, 16'(w[13:11]));
    mdl.prep();
    mdl.stackAdjust = STK_POP;
    mdl.issue(CLS_LOAD_MISC);
    chk("top", 16'h0, 16'(w[13:11]));
    $display("test stack done");
  endtask

  task t_exc();
    mdl.prep();
    mdl.excDetect = 6'h04;
    mdl.issue(CLS_ARITH);
    chk("word", 16'h8084, w & 16'hbaff);
    chk("handler", 16'h1, 16'(handlerReq));
    mdl.prep();
    chk("handler", 16'h0, 16'(handlerReq));
    mdl.issue(CLS_ARITH);
    chk("sticky", 16'h8084, w & 16'hbaff);
    mdl.prep();
    mdl.issue(CLS_CLEAR_EXC);
    chk("clear", 16'h0, w & 16'hb8ff);
    $display("test exception done");
  endtask

  task t_mask();
    controlMask = 6'h3f;
    mdl.prep();
    mdl.excDetect = 6'h20;
    mdl.roundedUp = 1'b1;
    mdl.issue(CLS_ARITH);
    chk("masked", 16'h0220, w & 16'hbaff);
    controlMask = 6'h1f;
    @(posedge clk);
    #1;
    chk("unmask", 16'h8000, w & 16'h8080 ^ 16'h0080);
    controlMask = 6'h00;
    mdl.prep();
    mdl.issue(CLS_CLEAR_EXC);
    $display("test mask done");
  endtask

  task t_fault();
    mdl.prep();
    {mdl.stackFault, mdl.stackOverflow} = 2'b11;
    mdl.issue(CLS_COMPARE_FLAGS);
    chk("ovf", 16'h0241, w & 16'h0241);
    mdl.prep();
    mdl.roundedUp = 1'b1;
    mdl.issue(CLS_LOAD_MISC);
    chk("load code one", 16'h0, 16'(w[9]));
    chk("sticky fault", 16'h1, 16'(w[6]));
    mdl.prep();
    mdl.stackFault = 1'b1;
    mdl.roundedUp = 1'b1;
    mdl.excDetect = 6'h20;
    mdl.issue(CLS_ARITH);
    chk("unf code one", 16'h0, 16'(w[9]));
    mdl.prep();
    mdl.issue(CLS_CLEAR_EXC);
    chk("fault clr", 16'h0, 16'(w[6]));
    $display("test fault done");
  endtask

  task t_ops();
    mdl.prep();
    mdl.operandSign = 1'b1;
    mdl.operandClass = 3'b101;
    mdl.issue(CLS_EXAMINE);
    chk("exam", 16'hb, 16'({w[14], w[10], w[9], w[8]}));
    mdl.prep();
    mdl.quotientLow = 3'b110;
    mdl.issue(CLS_REMAINDER);
    chk("rem", 16'h9, 16'({w[14], w[10], w[9], w[8]}));
    mdl.prep();
    mdl.quotientLow = 3'b001;
    mdl.issue(CLS_REMAINDER);
    chk("rem", 16'h2, 16'({w[14], w[10], w[9], w[8]}));
    mdl.prep();
    mdl.remIncomplete = 1'b1;
    mdl.issue(CLS_REMAINDER);
    chk("rem inc", 16'h1, 16'(w[10]));
    mdl.prep();
    mdl.trigOutOfRange = 1'b1;
    mdl.issue(CLS_TRIG);
    chk("trig", 16'h1, 16'(w[10]));
    mdl.prep();
    mdl.roundedUp = 1'b1;
    mdl.excDetect = 6'h20;
    mdl.issue(CLS_TRIG);
    chk("trig", 16'h1, 16'({w[10], w[9]}));
    $display("test ops done");
  endtask

  task t_image();
    mdl.prep();
    mdl.restoreWord = 16'h4501;
    mdl.issue(CLS_RESTORE);
    chk("restore", 16'hc581, w);
    mdl.prep();
    mdl.storeToAccumulator = 1'b1;
    mdl.issue(CLS_STORE_STATUS);
    chk("to acc", 16'h2, 16'({storeToAcc, storeToMem}));
    chk("store data", 16'hc581, storeData);
    chk("kept", 16'hc581, w);
    mdl.prep();
    chk("acc end", 16'h0, 16'(storeToAcc));
    mdl.issue(CLS_STORE_STATUS);
    chk("to mem", 16'h1, 16'({storeToAcc, storeToMem}));
    mdl.prep();
    mdl.issue(CLS_INIT);
    chk("init", 16'h0, w);
    $display("test image done");
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    chk("reset", 16'h0, w | storeData);
    chk("pulses", 16'h0, 16'({handlerReq, storeToAcc, storeToMem}));
    t_cmp();
    t_stack();
    t_exc();
    t_mask();
    t_fault();
    t_ops();
    t_image();
    results();
  end

  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule
